// ===== fpl_blink.sv
/*
  Shared blink timebase: a phase that toggles every half_period cycles and
  a one-cycle tick on each toggle. A half period of zero acts as one.
  Assumes half_period is a quasi-static setting.
*/
`timescale 1ns/1ps
module fpl_blink
  import fpl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [FPL_BLINK_W-1:0] half_period,
  output logic phase,
  output logic tick
);

  typedef struct packed {
    logic [FPL_BLINK_W-1:0] cnt;
    logic phase;
    logic tick;
  } fpl_blink_s;

  fpl_blink_s r;
  fpl_blink_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    // Comparing with >= lets a shortened period take effect at once.
    if (r.cnt + FPL_BLINK_W'(1) >= half_period)
    begin
      next_r.cnt = '0;
      next_r.phase = ~r.phase;
      next_r.tick = 1'b1;
    end
    else
    begin
      next_r.cnt = r.cnt + FPL_BLINK_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign phase = r.phase;
  assign tick = r.tick;

endmodule // fpl_blink

// ===== fpl_front_panel.sv
/*
  Front-panel indicator and select-button logic for one end of a fiber
  video extender, transmitter or receiver as chosen by a strap.
  Assumes status inputs come from logic on clk; the buttons and the knob
  come from pins and are synchronised here.
*/
// Contract
// - Self-test, then restore saved configuration, then run.
// - Dark mode keeps every status LED dark.
// - Transmitter power LED: blink ready, steady halted.
// - Receiver power LED blinks only when ready.
// - Protection LED: green encrypted, off, yellow-blink error.
// - Input LEDs reflect selection and valid video.
// - Conversion LED: green split, off, yellow subsample.
// - Laser LED red while optical transmitter active.
// - Locked panel press flashes LEDs green three times.
// - Select press toggles between input 1 and 2.
// - Button never enables, only disables, automatic choice.
// - Transmitter LEDs, backlight dark 60 s after enable.
// - First press in dark mode only wakes.
`timescale 1ns/1ps
module fpl_front_panel
  import fpl_pkg::*;
#(
  parameter logic [29:0] DARK_DELAY_CYC = FPL_DARK_DELAY_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic role_tx,
  input wire logic self_test_done,
  input wire logic cfg_restore_done,
  input wire fpl_status_s status,
  input wire logic dark_mode_en,
  input wire logic panel_lock,
  input wire logic auto_sel_set,
  input wire logic auto_sel_input,
  input wire logic [FPL_BLINK_W-1:0] blink_half_period,
  input wire logic button_pin,
  input wire logic knob_pin,
  output fpl_led_s led,
  output logic backlight_on,
  output logic self_test_req,
  output logic cfg_restore_req,
  output logic op_ready,
  output logic sel_input,
  output logic auto_sel_active,
  output logic func_press
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fpl_boot_e boot;
    logic is_tx;
    logic sel;
    logic auto_on;
    logic hidden;
    logic [29:0] dark_cnt;
    logic [2:0] flash_halves;
    logic btn_prev;
    logic knob_prev;
    logic func_press;
    logic self_test_req;
    logic cfg_restore_req;
    fpl_led_s led;
    logic backlight;
    logic op_ready;
  } fpl_fp_s;

  fpl_fp_s r;
  fpl_fp_s next_r;

  logic btn_level;
  logic knob_level;
  logic blink_phase;
  logic blink_tick;
  logic press;
  logic knob_move;
  logic contact;
  fpl_led_s normal;

  // ----------------------------------------------------------------
  // Pins and timebase
  // ----------------------------------------------------------------
  fpl_sync u_sync_btn (
    .clk(clk),
    .rst_n(rst_n),
    .pin(button_pin),
    .level(btn_level)
  );

  fpl_sync u_sync_knob (
    .clk(clk),
    .rst_n(rst_n),
    .pin(knob_pin),
    .level(knob_level)
  );

  // Every blinking LED follows this one timebase (phase, or tick for the lock flash) so they stay in step.
  fpl_blink u_blink (
    .clk(clk),
    .rst_n(rst_n),
    .half_period(blink_half_period),
    .phase(blink_phase),
    .tick(blink_tick)
  );

  assign press = btn_level & ~r.btn_prev;
  assign knob_move = knob_level ^ r.knob_prev;
  assign contact = press | knob_move;

  // ----------------------------------------------------------------
  // Indicator patterns
  // ----------------------------------------------------------------
  always_comb
  begin
    normal = FPL_LED_OFF;
    if (r.is_tx)
    begin
      if (status.power_good && status.out_of_op)
      begin
        normal.power_g = 1'b1;
      end
      else if (status.power_good && r.boot == FPL_BOOT_RUN)
      begin
        normal.power_g = blink_phase;
      end
    end
    else if (status.power_good && !status.out_of_op && r.boot == FPL_BOOT_RUN)
    begin
      normal.power_g = blink_phase;
    end
    if (status.link_err)
    begin
      normal.link_y = blink_phase;
    end
    else
    begin
      normal.link_g = status.link_ok;
    end
    if (status.enc_err)
    begin
      normal.prot_y = blink_phase;
    end
    else
    begin
      normal.prot_g = status.enc_on;
    end
    if (r.is_tx)
    begin
      // A single select bit means at most one input LED can be green.
      normal.in1_g = (r.sel == FPL_SEL_INPUT1) &&
                     (status.in_valid[0] || blink_phase);
      normal.in1_y = (r.sel != FPL_SEL_INPUT1) && status.in_valid[0];
      normal.in2_g = (r.sel == FPL_SEL_INPUT2) &&
                     (status.in_valid[1] || blink_phase);
      normal.in2_y = (r.sel != FPL_SEL_INPUT2) && status.in_valid[1];
    end
    else
    begin
      if (status.video_err)
      begin
        normal.sig_y = blink_phase;
      end
      else
      begin
        normal.sig_g = status.video_ok;
      end
      case (status.conv_mode)
        FPL_CONV_HALVES_SPLIT: normal.conv_g = 1'b1;
        FPL_CONV_CHROMA_SUB: normal.conv_y = 1'b1;
        default: normal.conv_g = 1'b0;
      endcase
    end
    normal.laser_r = status.laser_active;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.btn_prev = btn_level;
    next_r.knob_prev = knob_level;
    next_r.func_press = 1'b0;

    case (r.boot)
      FPL_BOOT_IDLE:
      begin
        // The strap is caught here, after reset has released.
        next_r.is_tx = role_tx;
        next_r.self_test_req = 1'b1;
        next_r.boot = FPL_BOOT_SELFTEST;
      end
      FPL_BOOT_SELFTEST:
      begin
        if (self_test_done)
        begin
          next_r.self_test_req = 1'b0;
          next_r.cfg_restore_req = 1'b1;
          next_r.boot = FPL_BOOT_RESTORE;
        end
      end
      FPL_BOOT_RESTORE:
      begin
        if (cfg_restore_done)
        begin
          next_r.cfg_restore_req = 1'b0;
          next_r.op_ready = 1'b1;
          next_r.boot = FPL_BOOT_RUN;
        end
      end
      FPL_BOOT_RUN:
      begin
        next_r.boot = FPL_BOOT_RUN;
      end
      default:
      begin
        next_r.boot = FPL_BOOT_IDLE;
      end
    endcase

    // Dark timer: the transmitter waits the delay, the receiver hides at once.
    if (!dark_mode_en)
    begin
      next_r.hidden = 1'b0;
      next_r.dark_cnt = '0;
    end
    else if (r.hidden && contact)
    begin
      next_r.hidden = 1'b0;
      next_r.dark_cnt = '0;
    end
    else if (!r.hidden)
    begin
      if (!r.is_tx || r.dark_cnt + 30'h1 >= DARK_DELAY_CYC)
      begin
        next_r.hidden = 1'b1;
        next_r.dark_cnt = '0;
      end
      else if (contact)
      begin
        next_r.dark_cnt = '0;
      end
      else
      begin
        next_r.dark_cnt = r.dark_cnt + 30'h1;
      end
    end

    // Automatic input choice: software may set it, the button only clears it.
    if (auto_sel_set)
    begin
      next_r.auto_on = 1'b1;
    end

    // Button actions run only when the press is not spent on waking.
    if (press && !r.hidden && r.boot == FPL_BOOT_RUN)
    begin
      if (panel_lock)
      begin
        next_r.flash_halves = FPL_LOCK_FLASH_HALVES;
      end
      else if (r.is_tx)
      begin
        next_r.sel = ~r.sel;
        next_r.auto_on = 1'b0;
      end
      else
      begin
        next_r.func_press = 1'b1;
      end
    end
    else if (r.auto_on && r.is_tx)
    begin
      next_r.sel = auto_sel_input;
    end

    if (r.flash_halves != 3'h0 && blink_tick)
    begin
      next_r.flash_halves = r.flash_halves - 3'h1;
    end

    // Output image: hidden beats the lock flash, which beats normal display.
    if (r.hidden)
    begin
      next_r.led = FPL_LED_OFF;
      next_r.backlight = 1'b0;
    end
    else if (r.flash_halves != 3'h0)
    begin
      next_r.led = FPL_LED_OFF;
      next_r.led.power_g = r.flash_halves[0];
      next_r.led.link_g = r.flash_halves[0];
      next_r.led.prot_g = r.flash_halves[0];
      next_r.led.in1_g = r.flash_halves[0] & r.is_tx;
      next_r.led.in2_g = r.flash_halves[0] & r.is_tx;
      next_r.led.sig_g = r.flash_halves[0] & ~r.is_tx;
      next_r.led.conv_g = r.flash_halves[0] & ~r.is_tx;
      next_r.led.laser_r = status.laser_active;
      next_r.backlight = 1'b1;
    end
    else
    begin
      next_r.led = normal;
      next_r.backlight = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign led = r.led;
  assign backlight_on = r.backlight;
  assign self_test_req = r.self_test_req;
  assign cfg_restore_req = r.cfg_restore_req;
  assign op_ready = r.op_ready;
  assign sel_input = r.sel;
  assign auto_sel_active = r.auto_on;
  assign func_press = r.func_press;

endmodule // fpl_front_panel

// ===== fpl_front_panel_assertions.sv
/*
  Port-level checker of the front-panel indicator block.
  Assumes it is bound to fpl_front_panel and the role strap stays still after reset.
*/
`timescale 1ns/1ps
module fpl_front_panel_assertions
  import fpl_pkg::*;
#(
  parameter logic [29:0] DARK_DELAY_CYC = FPL_DARK_DELAY_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic role_tx,
  input wire logic self_test_done,
  input wire fpl_status_s status,
  input wire logic dark_mode_en,
  input wire logic panel_lock,
  input wire logic auto_sel_set,
  input wire logic button_pin,
  input wire logic knob_pin,
  input wire fpl_led_s led,
  input wire logic backlight_on,
  input wire logic cfg_restore_req,
  input wire logic op_ready,
  input wire logic sel_input,
  input wire logic auto_sel_active
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Lock flash and wake-up linger, so normal display is judged only after two calm cycles.
  logic [1:0] calm;
  logic [31:0] dark_cnt;
  logic [3:0] press_age;
  wire logic plain = (&calm) && !dark_mode_en && !panel_lock;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calm <= 2'h0;
      dark_cnt <= 32'h0;
      press_age <= 4'hF;
    end
    else
    begin
      calm <= {calm[0], !dark_mode_en && !panel_lock};
      dark_cnt <= (dark_mode_en && !button_pin && !$changed(knob_pin)) ? dark_cnt + 32'h1 : 32'h0;
      press_age <= $rose(button_pin) ? 4'h0 : press_age + {3'h0, press_age != 4'hF};
    end
  end
  property p_toggle;
    role_tx && op_ready && plain && !auto_sel_active && $rose(button_pin)
      |-> ##[2:8] $changed(sel_input);
  endproperty
  property p_wake;
    dark_mode_en && !backlight_on && op_ready && $rose(button_pin)
      |-> ##1 $stable(sel_input) [*8];
  endproperty
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_boot_order: assert property ($rose(cfg_restore_req) |-> $past(self_test_done))
    else $error("restore began before self-test finished");
  a_tx_dark_off: assert property (
    role_tx && dark_cnt == 32'(DARK_DELAY_CYC) + 32'h6 |-> led == FPL_LED_OFF && !backlight_on)
    else $error("transmitter not dark after delay");
  a_dark_wake_only: assert property (p_wake)
    else $error("wake press changed the selection");
  a_sel_toggle: assert property (p_toggle)
    else $error("press did not toggle input");
  a_sel_cause: assert property (
    $changed(sel_input) && !auto_sel_active && !$past(auto_sel_active) |-> press_age < 4'hA)
    else $error("selection changed without a press");
  a_auto_set_only: assert property ($rose(auto_sel_active) |-> $past(auto_sel_set))
    else $error("automatic choice enabled without request");
  a_auto_press_clear: assert property (
    auto_sel_active && role_tx && op_ready && plain && $rose(button_pin) |-> ##[2:8] !auto_sel_active)
    else $error("press left automatic choice on");
  a_tx_halt_steady: assert property (
    role_tx && plain && status.power_good && status.out_of_op |=> led.power_g)
    else $error("halted transmitter power not steady");
  a_laser_follow: assert property (
    (!dark_mode_en) [*3] |=> led.laser_r == $past(status.laser_active))
    else $error("laser indicator wrong");
  a_conv_map: assert property (
    !role_tx && op_ready && plain && status.conv_mode != 2'h3 |=>
      {led.conv_g, led.conv_y} == {$past(status.conv_mode) == FPL_CONV_HALVES_SPLIT,
      $past(status.conv_mode) == FPL_CONV_CHROMA_SUB})
    else $error("conversion indicator wrong");
  a_blink_phase: assert property (
    plain && status.link_err && status.enc_err |=> led.link_y == led.prot_y)
    else $error("blinking indicators out of phase");
  c_boot: cover property ($rose(op_ready));
  c_toggle: cover property (role_tx && $rose(sel_input));
  c_dark: cover property (dark_cnt == 32'h10);
endmodule // fpl_front_panel_assertions

// ===== fpl_front_panel_tb_top.sv
/*
  Self-checking bench of the front-panel block, transmitter then receiver.
  Assumes the checker and operator model files are compiled before it.
*/
`timescale 1ns/1ps
module fpl_front_panel_tb_top;
  import fpl_pkg::*;
  localparam logic [29:0] DARK_CYC = 30'h32;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic role_tx = 1'b1;
  logic self_test_done = 1'b0;
  logic cfg_restore_done = 1'b0;
  fpl_status_s st = '0;
  logic dark_mode_en = 1'b0;
  logic panel_lock = 1'b0;
  logic auto_sel_set = 1'b0;
  logic auto_sel_input = 1'b0;
  logic [FPL_BLINK_W-1:0] half = 24'h8;
  logic button_pin;
  logic knob_pin;
  fpl_led_s led;
  logic backlight_on;
  logic self_test_req;
  logic cfg_restore_req;
  logic op_ready;
  logic sel_input;
  logic auto_sel_active;
  int failures = 0;
  int comparisons = 0;
  int flashes = 0;
  int fpresses = 0;
  logic func_press;
  logic pg_last = 1'b0;
  fpl_front_panel #(.DARK_DELAY_CYC(DARK_CYC)) i_fpl_front_panel (.clk(clk), .rst_n(rst_n),
    .role_tx(role_tx), .self_test_done(self_test_done), .cfg_restore_done(cfg_restore_done),
    .status(st), .dark_mode_en(dark_mode_en), .panel_lock(panel_lock),
    .auto_sel_set(auto_sel_set), .auto_sel_input(auto_sel_input), .blink_half_period(half),
    .button_pin(button_pin), .knob_pin(knob_pin), .led(led), .backlight_on(backlight_on),
    .self_test_req(self_test_req), .cfg_restore_req(cfg_restore_req), .op_ready(op_ready),
    .sel_input(sel_input), .auto_sel_active(auto_sel_active), .func_press(func_press));
  fpl_operator i_fpl_operator (.clk(clk), .button_pin(button_pin), .knob_pin(knob_pin));
  always #50 clk = ~clk;
  // Counts green flashes of the power indicator, and function presses, at every falling edge.
  always @(negedge clk)
  begin
    flashes += int'(led.power_g && !pg_last);
    fpresses += int'(func_press);
    pg_last = led.power_g;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic boot(input logic role);
    rst_n = 1'b0;
    role_tx = role;
    st = '0;
    cyc(6);
    rst_n = 1'b1;
    cyc(2);
    check(self_test_req, 1'b1);
    check(op_ready, 1'b0);
    self_test_done = 1'b1;
    cyc(1);
    self_test_done = 1'b0;
    check(cfg_restore_req, 1'b1);
    cfg_restore_done = 1'b1;
    cyc(1);
    cfg_restore_done = 1'b0;
    check(op_ready, 1'b1);
    $display("boot done");
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #(5000 * 100);
    failures++;
    results();
  end
  initial
  begin
    logic p;
    logic s;
    boot(1'b1);
    st.power_good = 1'b1;
    st.out_of_op = 1'b1;
    st.laser_active = 1'b1;
    st.link_ok = 1'b1;
    st.enc_on = 1'b1;
    st.in_valid = 2'h1;
    cyc(3);
    check(led.power_g, 1'b1);
    check(led.laser_r, 1'b1);
    check(led.link_g, 1'b1);
    check(led.prot_g, 1'b1);
    check({led.in1_g, led.in1_y, led.in2_g, led.in2_y}, 4'h8);
    st = '0;
    st.in_valid = 2'h2;
    cyc(2);
    check({led.in2_g, led.in2_y}, 2'h1);
    check(led.power_g, 1'b0);
    st.power_good = 1'b1;
    st.link_err = 1'b1;
    st.enc_err = 1'b1;
    cyc(2);
    check({led.link_g, led.prot_g}, 2'h0);
    p = led.power_g;
    check({led.link_y, led.prot_y}, {p, p});
    cyc(8);
    check({led.power_g, led.link_y, led.prot_y}, {~p, ~p, ~p});
    $display("tx indicators done");
    st = '0;
    st.in_valid = 2'h3;
    i_fpl_operator.press();
    check(sel_input, FPL_SEL_INPUT2);
    check({led.in1_g, led.in1_y, led.in2_g, led.in2_y}, 4'h6);
    i_fpl_operator.press();
    check(sel_input, FPL_SEL_INPUT1);
    $display("select done");
    auto_sel_input = 1'b1;
    auto_sel_set = 1'b1;
    cyc(1);
    auto_sel_set = 1'b0;
    cyc(3);
    check({auto_sel_active, sel_input}, 2'h3);
    i_fpl_operator.press();
    check({auto_sel_active, sel_input}, 2'h0);
    i_fpl_operator.press();
    check({auto_sel_active, sel_input}, 2'h1);
    $display("auto choice done");
    st = '0;
    panel_lock = 1'b1;
    s = sel_input;
    cyc(2);
    flashes = 0;
    i_fpl_operator.press();
    cyc(70);
    check(flashes, 3);
    check(sel_input, s);
    panel_lock = 1'b0;
    $display("lock done");
    st.laser_active = 1'b1;
    dark_mode_en = 1'b1;
    cyc(70);
    check({backlight_on, led}, 15'h0);
    i_fpl_operator.press();
    check(sel_input, s);
    check({backlight_on, led.laser_r}, 2'h3);
    cyc(70);
    check(backlight_on, 1'b0);
    i_fpl_operator.turn();
    check(backlight_on, 1'b1);
    dark_mode_en = 1'b0;
    $display("tx dark done");
    boot(1'b0);
    st.out_of_op = 1'b1;
    st.power_good = 1'b1;
    st.video_ok = 1'b1;
    st.in_valid = 2'h3;
    st.laser_active = 1'b1;
    cyc(2);
    check({led.power_g, led.sig_g}, 2'h1);
    check({led.in1_g, led.in1_y, led.in2_g, led.in2_y}, 4'h0);
    st.video_err = 1'b1;
    st.out_of_op = 1'b0;
    cyc(2);
    p = led.sig_y;
    check({led.sig_g, led.power_g}, {1'b0, p});
    cyc(8);
    check({led.sig_y, led.power_g}, {~p, ~p});
    for (int m = 0; m < 3; m++)
    begin
      st.conv_mode = 2'(m);
      cyc(2);
      check({led.conv_g, led.conv_y}, {m == 1, m == 2});
    end
    dark_mode_en = 1'b1;
    cyc(3);
    check(led, 14'h0);
    i_fpl_operator.press();
    check(fpresses, 0);
    dark_mode_en = 1'b0;
    cyc(2);
    check(led.laser_r, 1'b1);
    i_fpl_operator.press();
    check(fpresses, 1);
    $display("rx done");
    results();
  end
endmodule // fpl_front_panel_tb_top

bind fpl_front_panel fpl_front_panel_assertions #(.DARK_DELAY_CYC(DARK_DELAY_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .role_tx(role_tx), .self_test_done(self_test_done),
  .status(status), .dark_mode_en(dark_mode_en), .panel_lock(panel_lock),
  .auto_sel_set(auto_sel_set), .button_pin(button_pin), .knob_pin(knob_pin), .led(led),
  .backlight_on(backlight_on), .cfg_restore_req(cfg_restore_req), .op_ready(op_ready),
  .sel_input(sel_input), .auto_sel_active(auto_sel_active));

// ===== fpl_operator.sv
/*
  Model of the person at the front panel: presses the button, turns the knob.
  Assumes the clock of the block; pins change just after a falling edge.
*/
`timescale 1ns/1ps
module fpl_operator
(
  input wire logic clk,
  output logic button_pin,
  output logic knob_pin
);
  // ----------------------------------------------------------------
  // Actions
  // ----------------------------------------------------------------
  initial
  begin
    button_pin = 1'b0;
    knob_pin = 1'b0;
  end
  // A press is held long enough to pass the synchroniser and settle after release.
  task automatic press();
    @(negedge clk);
    button_pin = 1'b1;
    repeat (10) @(negedge clk);
    button_pin = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic turn();
    @(negedge clk);
    knob_pin = !knob_pin;
    repeat (10) @(negedge clk);
  endtask
endmodule // fpl_operator

// ===== fpl_pkg.sv
/*
  Shared constants, states and carrier types of the front-panel indicator block.
  Assumes one 10 MHz system clock and an active-low asynchronous reset.
*/
package fpl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned FPL_CLK_HZ = 10_000_000;
  localparam int unsigned FPL_DARK_DELAY_S = 60;
  localparam logic [29:0] FPL_DARK_DELAY_CYC = 30'(64'(FPL_DARK_DELAY_S) * 64'(FPL_CLK_HZ));
  localparam int unsigned FPL_BLINK_W = 24;
  localparam logic [2:0] FPL_LOCK_FLASH_HALVES = 3'h6;
  localparam int unsigned FPL_SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FPL_CONV_PASSTHROUGH = 2'h0;
  localparam logic [1:0] FPL_CONV_HALVES_SPLIT = 2'h1;
  localparam logic [1:0] FPL_CONV_CHROMA_SUB = 2'h2;
  localparam logic FPL_SEL_INPUT1 = 1'h0;
  localparam logic FPL_SEL_INPUT2 = 1'h1;

  typedef enum logic [1:0] {
    FPL_BOOT_IDLE = 2'b00,
    FPL_BOOT_SELFTEST = 2'b01,
    FPL_BOOT_RESTORE = 2'b10,
    FPL_BOOT_RUN = 2'b11
  } fpl_boot_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_good;
    logic out_of_op;
    logic link_ok;
    logic link_err;
    logic enc_on;
    logic enc_err;
    logic [1:0] in_valid;
    logic video_ok;
    logic video_err;
    logic [1:0] conv_mode;
    logic laser_active;
  } fpl_status_s;

  typedef struct packed {
    logic power_g;
    logic link_g;
    logic link_y;
    logic prot_g;
    logic prot_y;
    logic in1_g;
    logic in1_y;
    logic in2_g;
    logic in2_y;
    logic sig_g;
    logic sig_y;
    logic conv_g;
    logic conv_y;
    logic laser_r;
  } fpl_led_s;

  localparam fpl_led_s FPL_LED_OFF = '0;

endpackage

// ===== fpl_sync.sv
/*
  Three-stage synchroniser for one pin; the output changes only when the
  second and third stages agree, which also rejects single-cycle glitches.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module fpl_sync
  import fpl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic [FPL_SYNC_STAGES-1:0] stage;
    logic level;
  } fpl_sync_s;

  fpl_sync_s r;
  fpl_sync_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.stage = {r.stage[FPL_SYNC_STAGES-2:0], pin};
    if (r.stage[1] == r.stage[2])
    begin
      next_r.level = r.stage[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign level = r.level;

endmodule // fpl_sync
